//--- logic/ext_irq_defs.vh
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH
// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_MASK 12'h004
`define OFF_FLAG 12'h008
`define OFF_STAT 12'h00c
`define OFF_IMASK 12'h010
// Control register fields
`define CTRL_MODE_BIT 0
`define CTRL_GDIS_BIT 1
// Flag, mask and status bit positions
`define SRC_A 0
`define SRC_B 1
`define SRC_C 2
`define SRC_NMI 3
// Reset values
`define CTRL_RST 2'h2
`define MASK_RST 3'h0
// Vector codes of the request output
`define VEC_NONE 3'h0
`define VEC_NMI 3'h1
`define VEC_A 3'h2
`define VEC_B 3'h3
`define VEC_C 3'h4
`define VEC_HOLD 3'h5
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- logic/edge_catch.v
`include "ext_irq_defs.vh"
// Falling edge detector for an active-low interrupt pin
module edge_catch (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Pin level and detected edge
   input wire pin_n,
   output wire fall
);
   reg prev_r;
   // Previous level, idle high after reset
   always @(posedge aclk) begin
      if (!aresetn)
         prev_r <= 1'b1;
      else
         prev_r <= pin_n;
   end
   assign fall = prev_r & ~pin_n;
endmodule

//--- logic/external_interrupt_pins.v
// Overview of operation
// R1 - Shared hold/first interrupt pin always enters through the interrupt logic.
// R2 - Role bit 0: shared pin raises a bus-release request for software to service.
// R3 - Reset clears the role bit, starting the shared pin in bus-release mode.
// R4 - Second and third interrupts fixed priority, individually masked, globally disabled.
// R5 - Pending second and third interrupts latch in the flag register, cleared singly.
// R6 - Nonmaskable input ignores mask and global disable, forcing its own vector.
// R7 - Role bit 1: shared pin behaves as an ordinary maskable interrupt.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`include "ext_irq_defs.vh"
module external_interrupt_pins (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // External pins, active low
   input wire hold_irq_a_n,
   input wire ext_irq_b_n,
   input wire ext_irq_c_n,
   input wire nmi_n,
   // CPU side
   input wire cpu_ack,
   output reg cpu_req,
   output reg [2:0] cpu_vec,
   output reg hold_req,
   output wire irq
);
   reg [1:0] irq_control_reg_r;
   reg [2:0] irq_mask_reg_r;
   reg [2:0] irq_flag_reg_r;
   reg nmi_pend_r;
   reg [3:0] stat_r;
   reg [3:0] imask_r;
   reg [11:0] awaddr_r;
   reg aw_have_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_have_r;
   reg [2:0] flag_nxt;
   reg nmi_nxt;
   reg [3:0] stat_nxt;
   reg [2:0] vec_nxt;
   reg [31:0] rd_nxt;
   reg rd_ok;
   wire fall_a;
   wire fall_b;
   wire fall_c;
   wire fall_nmi;
   wire mode_irq;
   wire gdis;
   wire do_write;
   wire wr_ctrl;
   wire wr_mask;
   wire wr_flag;
   wire wr_stat;
   wire wr_imask;
   wire wr_ok;
   wire [3:0] events;
   wire [2:0] enabled;
   wire take;

   // One edge detector per pin
   edge_catch u_a (.aclk(aclk), .aresetn(aresetn), .pin_n(hold_irq_a_n), .fall(fall_a));
   edge_catch u_b (.aclk(aclk), .aresetn(aresetn), .pin_n(ext_irq_b_n), .fall(fall_b));
   edge_catch u_c (.aclk(aclk), .aresetn(aresetn), .pin_n(ext_irq_c_n), .fall(fall_c));
   edge_catch u_n (.aclk(aclk), .aresetn(aresetn), .pin_n(nmi_n), .fall(fall_nmi));

   assign mode_irq = irq_control_reg_r[`CTRL_MODE_BIT];
   assign gdis = irq_control_reg_r[`CTRL_GDIS_BIT];

   // Write channel: address and data accepted in either order
   assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
   assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
   assign wr_ctrl = do_write && (awaddr_r == `OFF_CTRL) && wstrb_r[0];
   assign wr_mask = do_write && (awaddr_r == `OFF_MASK) && wstrb_r[0];
   assign wr_flag = do_write && (awaddr_r == `OFF_FLAG) && wstrb_r[0];
   assign wr_stat = do_write && (awaddr_r == `OFF_STAT) && wstrb_r[0];
   assign wr_imask = do_write && (awaddr_r == `OFF_IMASK) && wstrb_r[0];
   assign wr_ok = (awaddr_r == `OFF_CTRL) || (awaddr_r == `OFF_MASK) ||
      (awaddr_r == `OFF_FLAG) || (awaddr_r == `OFF_STAT) || (awaddr_r == `OFF_IMASK);

   // Bus write handshake and response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control and mask registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_control_reg_r <= `CTRL_RST; // R3
         irq_mask_reg_r <= `MASK_RST;
         imask_r <= 4'h0;
      end else begin
         if (wr_ctrl)
            irq_control_reg_r <= wdata_r[1:0];
         if (wr_mask)
            irq_mask_reg_r <= wdata_r[2:0]; // R4
         if (wr_imask)
            imask_r <= wdata_r[3:0];
      end
   end

   // All four pin events feed the sticky status, in either role of the shared pin
   assign events = {fall_nmi, fall_c, fall_b, fall_a};

   // Pending flags: set wins over clear by software or acknowledge
   always @* begin
      flag_nxt = irq_flag_reg_r;
      nmi_nxt = nmi_pend_r;
      if (wr_flag)
         flag_nxt = flag_nxt & ~wdata_r[2:0]; // R5
      if (take) begin
         case (cpu_vec)
            `VEC_NMI: nmi_nxt = 1'b0;
            `VEC_A, `VEC_HOLD: flag_nxt[`SRC_A] = 1'b0; // R1
            `VEC_B: flag_nxt[`SRC_B] = 1'b0;
            `VEC_C: flag_nxt[`SRC_C] = 1'b0;
            default: flag_nxt = flag_nxt;
         endcase
      end
      if (fall_a)
         flag_nxt[`SRC_A] = 1'b1; // R1
      if (fall_b)
         flag_nxt[`SRC_B] = 1'b1; // R5
      if (fall_c)
         flag_nxt[`SRC_C] = 1'b1; // R5
      if (fall_nmi)
         nmi_nxt = 1'b1;
      stat_nxt = stat_r;
      if (wr_stat)
         stat_nxt = stat_nxt & ~wdata_r[3:0];
      stat_nxt = stat_nxt | events;
   end

   assign take = cpu_req & cpu_ack;
   assign enabled = irq_flag_reg_r & irq_mask_reg_r & {3{~gdis}};

   // Fixed priority: nonmaskable, shared pin, second, third
   always @* begin
      vec_nxt = `VEC_NONE;
      if (nmi_pend_r)
         vec_nxt = `VEC_NMI; // R6
      else if (enabled[`SRC_A])
         vec_nxt = mode_irq ? `VEC_A : `VEC_HOLD; // R7
      else if (enabled[`SRC_B])
         vec_nxt = `VEC_B; // R4
      else if (enabled[`SRC_C])
         vec_nxt = `VEC_C; // R4
   end

   // Flag state and CPU request outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_flag_reg_r <= 3'h0;
         nmi_pend_r <= 1'b0;
         stat_r <= 4'h0;
         cpu_req <= 1'b0;
         cpu_vec <= `VEC_NONE;
         hold_req <= 1'b0;
      end else begin
         irq_flag_reg_r <= flag_nxt;
         nmi_pend_r <= nmi_nxt;
         stat_r <= stat_nxt;
         if (take) begin
            cpu_req <= 1'b0;
            cpu_vec <= `VEC_NONE;
         end else if (!cpu_req && (vec_nxt != `VEC_NONE)) begin
            cpu_req <= 1'b1;
            cpu_vec <= vec_nxt;
         end
         // Bus-release request level while role bit is clear
         hold_req <= ~mode_irq & irq_flag_reg_r[`SRC_A]; // R2
      end
   end

   assign irq = |(stat_r & imask_r);

   // Read decode
   always @* begin
      rd_nxt = 32'h00000000;
      rd_ok = 1'b1;
      if ({s_axi_araddr[11:2], 2'h0} == `OFF_CTRL)
         rd_nxt[1:0] = irq_control_reg_r;
      else if ({s_axi_araddr[11:2], 2'h0} == `OFF_MASK)
         rd_nxt[2:0] = irq_mask_reg_r;
      else if ({s_axi_araddr[11:2], 2'h0} == `OFF_FLAG)
         rd_nxt[3:0] = {nmi_pend_r, irq_flag_reg_r};
      else if ({s_axi_araddr[11:2], 2'h0} == `OFF_STAT)
         rd_nxt[3:0] = stat_r;
      else if ({s_axi_araddr[11:2], 2'h0} == `OFF_IMASK)
         rd_nxt[3:0] = imask_r;
      else
         rd_ok = 1'b0;
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // Read response register
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_nxt;
         s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

//--- sim/ext_irq_monitor.sv
`include "ext_irq_defs.vh"
module ext_irq_monitor (
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // CPU side
   input logic cpu_req,
   input logic cpu_ack,
   input logic [2:0] cpu_vec,
   input logic hold_req,
   // Pin and read channel
   input logic nmi_n,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Nonmaskable event and its service
   sequence nmi_fall;
      $fell(nmi_n);
   endsequence
   sequence nmi_served;
      cpu_req && cpu_vec == `VEC_NMI;
   endsequence
   a_nmi_vec: assert property (nmi_fall |-> ##[2:16] nmi_served)
      else $error("nmi not served");
   a_req_stands: assert property (cpu_req && !cpu_ack |=> cpu_req && $stable(cpu_vec))
      else $error("request dropped early");
   a_ack_drop: assert property (cpu_req && cpu_ack |=> !cpu_req)
      else $error("request kept after ack");
   a_vec_valid: assert property (cpu_req |-> cpu_vec inside {[3'h1:3'h5]})
      else $error("bad vector");
   a_hold_vec: assert property (cpu_req && cpu_vec == `VEC_HOLD |-> hold_req)
      else $error("hold vector without hold");
   a_role_one: assert property (cpu_req && cpu_vec == `VEC_A |-> !hold_req)
      else $error("hold in irq role");
   a_reset_idle: assert property ($rose(aresetn) |-> !cpu_req && !hold_req)
      else $error("busy after reset");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data moved");
endmodule
bind external_interrupt_pins ext_irq_monitor i_ext_irq_monitor (.aclk, .aresetn, .cpu_req,
   .cpu_ack, .cpu_vec, .hold_req, .nmi_n, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

//--- sim/irq_partner.sv
module irq_partner (
   // Clock and CPU handshake
   input logic aclk,
   input logic cpu_req,
   output logic cpu_ack = 1'h0,
   // Bench controls
   input logic [3:0] fire,
   input logic [3:0] ack_wait,
   // Active-low pins, idle high as if pulled up
   output logic hold_irq_a_n,
   output logic ext_irq_b_n,
   output logic ext_irq_c_n,
   output logic nmi_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] pins = 4'hf, prev = 4'h0, cnt = 4'h0;
   assign {nmi_n, ext_irq_c_n, ext_irq_b_n, hold_irq_a_n} = pins;
   // Each request holds its pin low for two cycles
   always @(posedge aclk) begin
      prev <= fire;
      pins <= ~(fire | prev);
   end
   // CPU takes each request after a chosen wait
   always @(posedge aclk) begin
      cnt <= cpu_req ? cnt + 4'h1 : 4'h0;
      cpu_ack <= cpu_req && !cpu_ack && cnt >= ack_wait;
   end
endmodule

//--- sim/tb_external_interrupt_pins.sv
`include "ext_irq_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_external_interrupt_pins;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf, fire = '0, ack_wait = '0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire hold_irq_a_n, ext_irq_b_n, ext_irq_c_n, nmi_n, cpu_ack, cpu_req, hold_req;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0] cpu_vec;
   int fail_count = 0, compares = 0;
   logic [33:0] rq[$], er;
   logic [1:0] bq[$], eb;
   logic [2:0] vq[$], evv;
   external_interrupt_pins i_external_interrupt_pins (.*);
   irq_partner i_irq_partner (.*);
   always #12.5 aclk = ~aclk;
   // Ends the run with the verdict
   task close_out;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Register write with expected response
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
      bq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   // Register read, ready held back one cycle
   task rd(input logic [11:0] a, input logic [31:0] d);
      rq.push_back({`RESP_OKAY, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      @(posedge aclk);
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   // Pin events with a random CPU wait
   task ev(input logic [3:0] f);
      @(posedge aclk);
      fire <= f;
      ack_wait <= 4'($urandom % 8);
      @(posedge aclk);
      fire <= '0;
      repeat (6) @(posedge aclk);
      while (vq.size()) @(posedge aclk);
      // Let the acknowledge clear its flag and the hold level follow
      repeat (2) @(posedge aclk);
   endtask
   // Results taken against the oldest note
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         eb = bq.pop_front();
         `CHK("bresp", eb, s_axi_bresp)
      end
      if (s_axi_rvalid && s_axi_rready) begin
         er = rq.pop_front();
         `CHK("rdata", er, {s_axi_rresp, s_axi_rdata})
      end
      if (cpu_req && cpu_ack) begin
         evv = vq.pop_front();
         `CHK("vec", evv, cpu_vec)
      end
   end
   initial begin
      #(25ns * 20000);
      fail_count++;
      close_out;
   end
   // Main sequence
   initial begin
      void'($urandom(59697));
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`OFF_CTRL, 32'h2);
      rd(`OFF_MASK, 32'h0);
      wr(12'h0fc, $urandom, `RESP_SLVERR);
      ev(4'h1);
      `CHK("hold", 1'h1, hold_req)
      rd(`OFF_FLAG, 32'h1);
      vq.push_back(`VEC_HOLD);
      wr(`OFF_MASK, 32'h7);
      wr(`OFF_CTRL, 32'h0);
      ev(4'h0);
      `CHK("hold", 1'h0, hold_req)
      rd(`OFF_FLAG, 32'h0);
      wr(`OFF_CTRL, 32'h1);
      vq = '{`VEC_B, `VEC_C};
      ev(4'h6);
      vq = '{`VEC_NMI, `VEC_A, `VEC_B};
      ev(4'hb);
      wr(`OFF_MASK, 32'h0);
      ev(4'h6);
      rd(`OFF_FLAG, 32'h6);
      wr(`OFF_FLAG, 32'h4);
      rd(`OFF_FLAG, 32'h2);
      wr(`OFF_CTRL, 32'h3);
      vq = '{`VEC_NMI};
      ev(4'h8);
      wr(`OFF_MASK, 32'h2);
      ev(4'h0);
      `CHK("req", 1'h0, cpu_req)
      vq = '{`VEC_B};
      wr(`OFF_CTRL, 32'h1);
      ev(4'h0);
      wr(`OFF_STAT, 32'hf);
      rd(`OFF_STAT, 32'h0);
      wr(`OFF_MASK, 32'h0);
      ev(4'h2);
      rd(`OFF_STAT, 32'h2);
      `CHK("irq", 1'h0, irq)
      wr(`OFF_IMASK, 32'h2);
      `CHK("irq", 1'h1, irq)
      wr(`OFF_FLAG, 32'h2);
      wr(`OFF_STAT, 32'h2);
      `CHK("irq", 1'h0, irq)
      close_out;
   end
endmodule
